// ---- rtl/agc_cfg_if.sv ----
// Interface: raw gain-control field codes from register file to decode logic
`timescale 1ns/100ps
interface agc_cfg_if;
	logic [1:0] digital_gain_limit;
	logic [2:0] front_amp_gain_limit;
	logic [2:0] amplitude_target;
	logic       amp_reduction_order;
	logic [1:0] relative_carrier_threshold;
	logic [3:0] absolute_carrier_threshold;
	modport src (output digital_gain_limit, front_amp_gain_limit, amplitude_target,
		amp_reduction_order, relative_carrier_threshold, absolute_carrier_threshold);
	modport dst (input digital_gain_limit, front_amp_gain_limit, amplitude_target,
		amp_reduction_order, relative_carrier_threshold, absolute_carrier_threshold);
endinterface

// ---- rtl/agc_decode.sv ----
// Decode of gain-control settings into values the gain loop and carrier sense use
`timescale 1ns/100ps
module agc_decode #(
	parameter int DIG_STEPS = agc_pkg::DIG_STEPS
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 clk_en,
	agc_cfg_if.dst                    cfg,
	output logic [DIG_STEPS-1:0]      digital_step_allowed,
	output logic [7:0]                front_amp_backoff_tenth_db,
	output logic [5:0]                amplitude_target_db,
	output logic                      first_amp_reduced_first,
	output logic                      rel_sense_enable,
	output logic [3:0]                rel_sense_rise_db,
	output logic                      abs_sense_enable,
	output logic signed [4:0]         abs_sense_offset_db
);
	// Limit codes clear up to three top steps, so at least four must exist
	if (DIG_STEPS < 4) begin : g_steps_check
		$error("agc_decode: DIG_STEPS must be at least 4");
	end

	logic [DIG_STEPS-1:0] step_d, step_q;
	logic [7:0]           backoff_d, backoff_q;
	logic [5:0]           target_d, target_q;
	logic                 order_d, order_q;
	logic                 rel_en_d, rel_en_q;
	logic [3:0]           rise_d, rise_q;
	logic                 abs_en_d, abs_en_q;
	logic signed [4:0]    abs_off_d, abs_off_q;

	always_comb begin
		// Top steps masked off by limit code
		step_d = '1;
		for (int i = 0; i < 3; i++) begin
			if (i < int'(cfg.digital_gain_limit))
				step_d[DIG_STEPS-1-i] = 1'b0;
		end
		unique case (cfg.front_amp_gain_limit)
			3'd0: backoff_d = 8'd0;
			3'd1: backoff_d = 8'd26;
			3'd2: backoff_d = 8'd61;
			3'd3: backoff_d = 8'd74;
			3'd4: backoff_d = 8'd92;
			3'd5: backoff_d = 8'd115;
			3'd6: backoff_d = 8'd146;
			3'd7: backoff_d = 8'd171;
		endcase
		unique case (cfg.amplitude_target)
			3'd0: target_d = 6'd24;
			3'd1: target_d = 6'd27;
			3'd2: target_d = 6'd30;
			3'd3: target_d = 6'd33;
			3'd4: target_d = 6'd36;
			3'd5: target_d = 6'd38;
			3'd6: target_d = 6'd40;
			3'd7: target_d = 6'd42;
		endcase
		order_d  = cfg.amp_reduction_order;
		rel_en_d = cfg.relative_carrier_threshold != agc_pkg::REL_THR_OFF;
		unique case (cfg.relative_carrier_threshold)
			2'd0: rise_d = 4'd0;
			2'd1: rise_d = 4'd6;
			2'd2: rise_d = 4'd10;
			2'd3: rise_d = 4'd14;
		endcase
		abs_en_d  = cfg.absolute_carrier_threshold != agc_pkg::ABS_THR_DISABLED;
		abs_off_d = 5'(signed'(cfg.absolute_carrier_threshold));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_q    <= '1;
			backoff_q <= 8'h00;
			target_q  <= 6'd33;
			order_q   <= 1'b1;
			rel_en_q  <= 1'b0;
			rise_q    <= 4'h0;
			abs_en_q  <= 1'b1;
			abs_off_q <= 5'sd0;
		end else if (clk_en) begin
			step_q    <= step_d;
			backoff_q <= backoff_d;
			target_q  <= target_d;
			order_q   <= order_d;
			rel_en_q  <= rel_en_d;
			rise_q    <= rise_d;
			abs_en_q  <= abs_en_d;
			abs_off_q <= abs_off_d;
		end
	end

	assign digital_step_allowed       = step_q;
	assign front_amp_backoff_tenth_db = backoff_q;
	assign amplitude_target_db        = target_q;
	assign first_amp_reduced_first    = order_q;
	assign rel_sense_enable           = rel_en_q;
	assign rel_sense_rise_db          = rise_q;
	assign abs_sense_enable           = abs_en_q;
	assign abs_sense_offset_db        = abs_off_q;
endmodule

// ---- rtl/agc_gain_limit_config.sv ----
// Top: APB register bank holding gain limits, target and carrier-sense settings
//
// Functional notes
// - Digital limit code excludes top gain steps
// - Front limit caps combined amplifier gain
// - Target code selects averaged amplitude level
// - Priority bit picks which amplifier drops first
// - Relative carrier-sense rise: off, 6, 10, 14 dB
// - Most negative absolute code disables sensing
`timescale 1ns/100ps
module agc_gain_limit_config #(
	parameter int DIG_STEPS = agc_pkg::DIG_STEPS
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                clk_en,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [9:0]          paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic                     pready,
	output logic [31:0]              prdata,
	output logic                     pslverr,
	input  wire logic                carrier_sense_rel,
	input  wire logic                carrier_sense_abs,
	output logic [DIG_STEPS-1:0]     digital_step_allowed,
	output logic [7:0]               front_amp_backoff_tenth_db,
	output logic [5:0]               amplitude_target_db,
	output logic                     first_amp_reduced_first,
	output logic                     rel_sense_enable,
	output logic [3:0]               rel_sense_rise_db,
	output logic                     abs_sense_enable,
	output logic signed [4:0]        abs_sense_offset_db
);
	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic [7:0]  limit_target_d, limit_target_q;
	logic [6:0]  prio_carrier_d, prio_carrier_q;
	logic [31:0] prdata_d, prdata_q;
	logic        pslverr_d, pslverr_q;
	logic        sense_hold_d, sense_hold_q;

	agc_cfg_if cfg ();

	logic access;
	logic wr;
	logic rd;
	logic hit;

	// Zero-wait slave: every access completes in its first access cycle
	assign access  = psel && penable;
	assign pready  = 1'b1;
	assign wr      = access && pwrite && clk_en;
	assign rd      = psel && !penable && !pwrite;
	assign hit     = (paddr == agc_pkg::LIMIT_TARGET_ADDR) ||
		(paddr == agc_pkg::PRIO_CARRIER_ADDR) ||
		(paddr == agc_pkg::RAW_CODES_ADDR) ||
		(paddr == agc_pkg::SENSE_STATUS_ADDR);

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		limit_target_d = limit_target_q;
		prio_carrier_d = prio_carrier_q;
		prdata_d       = prdata_q;
		pslverr_d      = pslverr_q;
		sense_hold_d   = sense_hold_q | carrier_sense_rel | carrier_sense_abs;
		if (wr && pstrb[0]) begin
			if (paddr == agc_pkg::LIMIT_TARGET_ADDR)
				limit_target_d = pwdata[7:0];
			if (paddr == agc_pkg::PRIO_CARRIER_ADDR)
				prio_carrier_d = pwdata[6:0];
		end
		if (wr && paddr == agc_pkg::SENSE_STATUS_ADDR && pwdata[0])
			sense_hold_d = carrier_sense_rel | carrier_sense_abs;
		if (psel && !penable) begin
			pslverr_d = !hit || (pwrite && (paddr == agc_pkg::RAW_CODES_ADDR));
			prdata_d  = 32'h0000_0000;
			if (rd) begin
				unique case (1'b1)
					paddr == agc_pkg::LIMIT_TARGET_ADDR:
						prdata_d = {24'h00_0000, limit_target_q};
					paddr == agc_pkg::PRIO_CARRIER_ADDR:
						prdata_d = {25'h000_0000, prio_carrier_q};
					paddr == agc_pkg::RAW_CODES_ADDR:
						prdata_d = {8'h00, 8'h00, 1'b0, prio_carrier_q, limit_target_q};
					paddr == agc_pkg::SENSE_STATUS_ADDR:
						prdata_d = {28'h000_0000, abs_sense_enable, rel_sense_enable,
							carrier_sense_rel | carrier_sense_abs, sense_hold_q};
					default:
						prdata_d = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			limit_target_q <= agc_pkg::LIMIT_TARGET_RST;
			prio_carrier_q <= agc_pkg::PRIO_CARRIER_RST[6:0];
			prdata_q       <= 32'h0000_0000;
			pslverr_q      <= 1'b0;
			sense_hold_q   <= 1'b0;
		end else if (clk_en) begin
			limit_target_q <= limit_target_d;
			prio_carrier_q <= prio_carrier_d;
			prdata_q       <= prdata_d;
			pslverr_q      <= pslverr_d;
			sense_hold_q   <= sense_hold_d;
		end
	end

	assign prdata  = prdata_q;
	assign pslverr = pslverr_q && access;

	// ------------------------------------------------------------
	// Field split
	// ------------------------------------------------------------
	assign cfg.digital_gain_limit         = limit_target_q[agc_pkg::DIG_LIMIT_LSB +: 2];
	assign cfg.front_amp_gain_limit       = limit_target_q[agc_pkg::FRONT_LIMIT_LSB +: 3];
	assign cfg.amplitude_target           = limit_target_q[agc_pkg::TARGET_LSB +: 3];
	assign cfg.amp_reduction_order        = prio_carrier_q[agc_pkg::ORDER_BIT];
	assign cfg.relative_carrier_threshold = prio_carrier_q[agc_pkg::REL_THR_LSB +: 2];
	assign cfg.absolute_carrier_threshold = prio_carrier_q[agc_pkg::ABS_THR_LSB +: 4];

	agc_decode #(
		.DIG_STEPS(DIG_STEPS)
	) u_decode (
		.pclk                       (pclk),
		.presetn                    (presetn),
		.clk_en                     (clk_en),
		.cfg                        (cfg),
		.digital_step_allowed       (digital_step_allowed),
		.front_amp_backoff_tenth_db (front_amp_backoff_tenth_db),
		.amplitude_target_db        (amplitude_target_db),
		.first_amp_reduced_first    (first_amp_reduced_first),
		.rel_sense_enable           (rel_sense_enable),
		.rel_sense_rise_db          (rel_sense_rise_db),
		.abs_sense_enable           (abs_sense_enable),
		.abs_sense_offset_db        (abs_sense_offset_db)
	);
endmodule

// ---- rtl/agc_pkg.sv ----
// Package: register map, field layout and reset values of the gain-control config block
package agc_pkg;
	// Byte addresses: printed offsets are not all multiples of four, so they are indexes
	localparam logic [7:0] LIMIT_TARGET_IDX   = 8'h1b;
	localparam logic [7:0] PRIO_CARRIER_IDX   = 8'h1c;
	localparam logic [9:0] LIMIT_TARGET_ADDR  = {LIMIT_TARGET_IDX, 2'b00};
	localparam logic [9:0] PRIO_CARRIER_ADDR  = {PRIO_CARRIER_IDX, 2'b00};
	localparam logic [9:0] RAW_CODES_ADDR     = 10'h0_080;
	localparam logic [9:0] SENSE_STATUS_ADDR  = 10'h0_084;

	// Field positions
	localparam int DIG_LIMIT_LSB   = 6;
	localparam int FRONT_LIMIT_LSB = 3;
	localparam int TARGET_LSB      = 0;
	localparam int ORDER_BIT       = 6;
	localparam int REL_THR_LSB     = 4;
	localparam int ABS_THR_LSB     = 0;

	// Reset values
	localparam logic [7:0] LIMIT_TARGET_RST = 8'h03;
	localparam logic [7:0] PRIO_CARRIER_RST = 8'h40;

	localparam logic [3:0] ABS_THR_DISABLED = 4'h8;
	localparam logic [1:0] REL_THR_OFF      = 2'h0;

	// Steps of the stages, given as step counts
	localparam int DIG_STEPS   = 8;
	localparam int FRONT_STEPS = 8;

	typedef enum logic [1:0] {
		AGC_IDLE   = 2'b01,
		AGC_ACCESS = 2'b10
	} agc_apb_state_t;
endpackage

// ---- tb/agc_gain_limit_config_assertions.sv ----
// Checker: gain-control register bank port assertions
`timescale 1ns/100ps
module agc_gain_limit_config_assertions #(
	parameter int DIG_STEPS = 8
) (
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic                 clk_en,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [9:0]           paddr,
	input wire logic [31:0]          pwdata,
	input wire logic [3:0]           pstrb,
	input wire logic                 pready,
	input wire logic [31:0]          prdata,
	input wire logic [DIG_STEPS-1:0] digital_step_allowed,
	input wire logic [7:0]           front_amp_backoff_tenth_db,
	input wire logic [5:0]           amplitude_target_db,
	input wire logic                 first_amp_reduced_first,
	input wire logic                 rel_sense_enable,
	input wire logic [3:0]           rel_sense_rise_db,
	input wire logic                 abs_sense_enable,
	input wire logic signed [4:0]    abs_sense_offset_db
);
	localparam int BKO[8] = '{0, 26, 61, 74, 92, 115, 146, 171};
	localparam int TGT[8] = '{24, 27, 30, 33, 36, 38, 40, 42};
	localparam int RISE[4] = '{0, 6, 10, 14};
	logic acc;
	logic wr_lt;
	logic wr_pc;
	assign acc = psel && penable && pready && clk_en;
	assign wr_lt = acc && pwrite && pstrb[0] && paddr == agc_pkg::LIMIT_TARGET_ADDR;
	assign wr_pc = acc && pwrite && pstrb[0] && paddr == agc_pkg::PRIO_CARRIER_ADDR;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// --------------------------------
	// Decoded outputs follow a write two edges later
	// --------------------------------
	dig_limit_a: assert property (wr_lt ##1 clk_en |=>
		digital_step_allowed == {DIG_STEPS{1'b1}} >> $past(pwdata[7:6], 2))
		else $error("step mask wrong");
	front_limit_a: assert property (wr_lt ##1 clk_en |=>
		front_amp_backoff_tenth_db == 8'(BKO[$past(pwdata[5:3], 2)]))
		else $error("front backoff wrong");
	amp_target_a: assert property (wr_lt ##1 clk_en |=>
		amplitude_target_db == 6'(TGT[$past(pwdata[2:0], 2)]))
		else $error("target wrong");
	amp_order_a: assert property (wr_pc ##1 clk_en |=>
		first_amp_reduced_first == $past(pwdata[6], 2))
		else $error("order wrong");
	rel_thr_a: assert property (wr_pc ##1 clk_en |=>
		rel_sense_enable == ($past(pwdata[5:4], 2) != 2'h0)
		&& rel_sense_rise_db == 4'(RISE[$past(pwdata[5:4], 2)]))
		else $error("relative sense wrong");
	abs_thr_a: assert property (wr_pc ##1 clk_en |=>
		abs_sense_enable == ($past(pwdata[3:0], 2) != agc_pkg::ABS_THR_DISABLED)
		&& abs_sense_offset_db == {$past(pwdata[3], 2), $past(pwdata[3:0], 2)})
		else $error("absolute sense wrong");
	unused_bit_a: assert property (acc && !pwrite && paddr == agc_pkg::PRIO_CARRIER_ADDR
		|-> prdata[31:7] == 25'h0)
		else $error("unused bit not zero");
	cover property (wr_lt);
	cover property (wr_pc);
	cover property (acc && !pwrite && paddr == agc_pkg::PRIO_CARRIER_ADDR);
endmodule
bind agc_gain_limit_config agc_gain_limit_config_assertions #(.DIG_STEPS(DIG_STEPS)) chk_u (.*);

// ---- tb/tb_agc_gain_limit_config.sv ----
// Testbench: writes, readback and decoded outputs of the gain-control bank
`timescale 1ns/100ps
module tb_agc_gain_limit_config;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic clk_en = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [9:0] paddr = 10'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'hf;
	logic carrier_sense_rel = 1'b0;
	logic carrier_sense_abs = 1'b0;
	logic pready;
	logic [31:0] prdata;
	logic pslverr;
	logic [7:0] digital_step_allowed;
	logic [7:0] front_amp_backoff_tenth_db;
	logic [5:0] amplitude_target_db;
	logic first_amp_reduced_first;
	logic rel_sense_enable;
	logic [3:0] rel_sense_rise_db;
	logic abs_sense_enable;
	logic signed [4:0] abs_sense_offset_db;
	logic [32:0] notes[$];
	logic [7:0] lt;
	logic [7:0] pc;
	int mismatches = 0;
	int total_checks = 0;
	int bko[8] = '{0, 26, 61, 74, 92, 115, 146, 171};
	int tgt[8] = '{24, 27, 30, 33, 36, 38, 40, 42};
	int rs[4] = '{0, 6, 10, 14};

	always #2 pclk = ~pclk;

	agc_gain_limit_config dut_u (.*);

	always @(posedge pclk) begin
		{carrier_sense_rel, carrier_sense_abs} <= 2'($urandom());
	end

	// --------------------------------
	// Bus tasks and comparison
	// --------------------------------
	task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'($urandom()), d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [9:0] a, input logic [32:0] e);
		notes.push_back(e);
		apb(1'b0, a, 8'h00);
	endtask

	// Read results checked against the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			chk("read", {pslverr, prdata}, notes.pop_front());
		end
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// --------------------------------
	// Tests
	// --------------------------------
	initial begin
		void'($urandom(42770));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		chk("steps", digital_step_allowed, 8'hff);
		chk("abs_en", abs_sense_enable, 1'b1);
		rd(agc_pkg::LIMIT_TARGET_ADDR, 33'h0_0000_0003);
		rd(agc_pkg::PRIO_CARRIER_ADDR, 33'h0_0000_0040);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			lt = {i[1:0], i[2:0], 3'(7 - i)};
			pc = {1'($urandom()), i[0], i[1:0], 4'(i + 5)};
			apb(1'b1, agc_pkg::LIMIT_TARGET_ADDR, lt);
			apb(1'b1, agc_pkg::PRIO_CARRIER_ADDR, pc);
			@(posedge pclk);
			@(negedge pclk);
			chk("steps", digital_step_allowed, 8'hff >> i[1:0]);
			chk("backoff", front_amp_backoff_tenth_db, bko[i]);
			chk("target", amplitude_target_db, tgt[7 - i]);
			chk("order", first_amp_reduced_first, i[0]);
			chk("rel", {rel_sense_enable, rel_sense_rise_db}, {pc[5:4] != 2'h0, 4'(rs[pc[5:4]])});
			chk("abs", {abs_sense_enable, abs_sense_offset_db}, {pc[3:0] != 4'h8, pc[3], pc[3:0]});
			rd(agc_pkg::LIMIT_TARGET_ADDR, {25'h0, lt});
			rd(agc_pkg::PRIO_CARRIER_ADDR, {26'h0, pc[6:0]});
			rd(agc_pkg::RAW_CODES_ADDR, {18'h0, pc[6:0], lt});
		end
		$display("test fields done");
		// Write without the byte-0 strobe must leave the register alone
		pstrb <= 4'he;
		apb(1'b1, agc_pkg::LIMIT_TARGET_ADDR, 8'h00);
		pstrb <= 4'hf;
		rd(agc_pkg::LIMIT_TARGET_ADDR, {25'h0, lt});
		rd(10'h3fc, 33'h1_0000_0000);
		// Write while frozen must not land
		clk_en <= 1'b0;
		apb(1'b1, agc_pkg::LIMIT_TARGET_ADDR, ~lt);
		repeat (4) @(posedge pclk);
		clk_en <= 1'b1;
		rd(agc_pkg::LIMIT_TARGET_ADDR, {25'h0, lt});
		@(negedge pclk);
		chk("target", amplitude_target_db, tgt[0]);
		$display("test refusals done");
		end_sim();
	end

	initial begin
		#100000;
		mismatches++;
		end_sim();
	end
endmodule
